//--- hw/sbcg_pkg.sv
package sbcg_pkg;
   // register byte addresses
   localparam logic [3:0] ADDR_BAUD_CTRL  = 4'h0; // baud_control_reg
   localparam logic [3:0] ADDR_BAUD_FRAC  = 4'h4; // baud_fraction_reg
   localparam logic [3:0] ADDR_SER_MODE   = 4'h8; // serial_mode_reg
   localparam logic [3:0] ADDR_SER_CTRL   = 4'hC; // serial_control_reg
   // baud_control_reg fields
   localparam int DIV_N_LSB    = 0;  // divide_ratio_n [3:0]
   localparam int IN_SEL_LSB   = 4;  // baud_input_select [5:4]
   localparam int FRAC_EN_BIT  = 6;  // fractional_divide_enable
   // baud_fraction_reg fields
   localparam int FRAC_K_LSB   = 0;  // fraction_k [3:0]
   // serial_mode_reg fields
   localparam int SRC_LSB      = 0;  // uart_clock_source [1:0]
   localparam int UART_MODE_BIT = 2; // 1 = uart, 0 = synchronous i/o
   // serial_control_reg fields
   localparam int EDGE_SEL_BIT = 0;  // serial_clock_edge_select
   localparam int DIR_BIT      = 1;  // serial_clock_direction
   // status read back in serial_control_reg
   localparam int RX_BIT_LSB   = 4;  // receive counter [7:4]
   localparam int RX_DATA_BIT  = 8;  // last majority bit
   // reset values
   localparam logic [6:0] BAUD_CTRL_RST = 7'h01;
   localparam logic [3:0] BAUD_FRAC_RST = 4'h0;
   localparam logic [2:0] SER_MODE_RST  = 3'h4;
   localparam logic [1:0] SER_CTRL_RST  = 2'h0;
   // clock source codes in uart mode
   localparam logic [1:0] SRC_BAUD  = 2'h0;
   localparam logic [1:0] SRC_HALF  = 2'h1;
   localparam logic [1:0] SRC_TIMER = 2'h2;
   localparam logic [1:0] SRC_EXT   = 2'h3;
   // receive counter sample points (7th, 8th, 9th pulse)
   localparam logic [3:0] SAMPLE_A = 4'h6;
   localparam logic [3:0] SAMPLE_B = 4'h7;
   localparam logic [3:0] SAMPLE_C = 4'h8;
   localparam logic [3:0] LAST_PULSE = 4'hF;
endpackage

//--- hw/sbcg_serial_baud_clock_gen.sv
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - two-bit select picks prescaler tap div1, div4, div16 or div64
// - fraction off: divide by integer n 1..16, fraction field ignored
// - fraction on in uart mode with k nonzero: divide by n plus (16 minus k)/16
// - uart bit rate is generator output over a further 16
// - uart may take halved system clock directly as basic clock
// - sync i/o clock out: basic and pin clock are generator output over 2
// - uart external clock: one bit per 16 periods, period >= 4 clocks
// - sync i/o clock in: basic clock from selected pin edge
// - uart source field picks generator, half clock, timer or pin
// - timer output never clocks synchronous i/o mode
// - timer-clocked uart rate is tap over compare value times 2 times 16
// - 4-bit receive counter advances per basic pulse, 16 per bit
// - sample 7th, 8th, 9th pulses, take majority as the bit
module sbcg_serial_baud_clock_gen
   import sbcg_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        prescaler_tap_div1,
   input  wire logic        prescaler_tap_div4,
   input  wire logic        prescaler_tap_div16,
   input  wire logic        prescaler_tap_div64,
   input  wire logic        timer_four_output,
   input  wire logic        serial_clock_pin_in,
   output logic             serial_clock_pin_out,
   output logic             serial_clock_pin_oe_n,
   input  wire logic        rx_line,
   output logic             uart_basic_clock,
   output logic             rx_bit_valid,
   output logic             rx_bit_value
);
   ////////////////////////////////////////////////////////////////////////
   // registers
   logic [6:0]  baud_control_q;
   logic [3:0]  baud_fraction_q;
   logic [2:0]  serial_mode_q;
   logic [1:0]  serial_control_q;
   logic        ack_q;
   logic [3:0]  rx_cnt_q;
   logic [2:0]  samp_q;
   logic        rx_bit_q;

   wire [3:0] divide_ratio_n   = baud_control_q[DIV_N_LSB +: 4];
   wire [1:0] baud_input_select = baud_control_q[IN_SEL_LSB +: 2];
   wire fractional_divide_enable = baud_control_q[FRAC_EN_BIT];
   wire [3:0] fraction_k       = baud_fraction_q[FRAC_K_LSB +: 4];
   wire [1:0] uart_clock_source = serial_mode_q[SRC_LSB +: 2];
   wire uart_mode = serial_mode_q[UART_MODE_BIT];
   wire serial_clock_edge_select = serial_control_q[EDGE_SEL_BIT];
   wire serial_clock_direction   = serial_control_q[DIR_BIT];

   // bus access one cycle wait then ack
   // waitrequest is registered, so every access costs exactly one wait
   wire req  = avs_read | avs_write;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req & ~ack_q;
      end
   end

   // waitrequest high until the ack cycle
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= ~(req & ~ack_q);
      end
   end

   // register writes
   // a write lands on the first edge the request is seen; the master
   // holds it through the wait, so landing early changes nothing
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         baud_control_q   <= BAUD_CTRL_RST;
         baud_fraction_q  <= BAUD_FRAC_RST;
         serial_mode_q    <= SER_MODE_RST;
         serial_control_q <= SER_CTRL_RST;
      end else if (avs_write && req && !ack_q) begin
         unique case (avs_address)
            ADDR_BAUD_CTRL: baud_control_q   <= avs_writedata[6:0];
            ADDR_BAUD_FRAC: baud_fraction_q  <= avs_writedata[3:0];
            ADDR_SER_MODE:  serial_mode_q    <= avs_writedata[2:0];
            ADDR_SER_CTRL:  serial_control_q <= avs_writedata[1:0];
            default: ;
         endcase
      end
   end

   // read data registered with the ack; unmapped reads as zero
   // status bits show the receive counter and the last decided bit
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         avs_readdata <= 32'h0000_0000;
      end else begin
         avs_readdata <= 32'h0000_0000;
         if (avs_read && !ack_q) begin
            unique case (avs_address)
               ADDR_BAUD_CTRL: avs_readdata[6:0] <= baud_control_q;
               ADDR_BAUD_FRAC: avs_readdata[3:0] <= baud_fraction_q;
               ADDR_SER_MODE:  avs_readdata[2:0] <= serial_mode_q;
               ADDR_SER_CTRL: begin
                  avs_readdata[1:0] <= serial_control_q;
                  avs_readdata[RX_BIT_LSB +: 4] <= rx_cnt_q;
                  avs_readdata[RX_DATA_BIT] <= rx_bit_q;
               end
               default: ;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // edge detection of clock-like inputs
   // one history flop each for the selected tap, the timer and the pin; taps are free-running level
   // clocks, so only their rising edge counts as an event
   logic       tap_q;
   logic       tmr_q;
   logic       pin_q;

   // rising edge of a sampled level
   function automatic logic rise(input logic now, input logic prev);
      return now & ~prev;
   endfunction

   logic tap_sel;
   always_comb begin
      unique case (baud_input_select)
         2'h0: tap_sel = prescaler_tap_div1;
         2'h1: tap_sel = prescaler_tap_div4;
         2'h2: tap_sel = prescaler_tap_div16;
         default: tap_sel = prescaler_tap_div64;
      endcase
   end

   // previous values for edge detection
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tap_q <= 1'b0;
         tmr_q <= 1'b0;
         pin_q <= 1'b1; // pin idles high, so no false edge after reset
      end else begin
         tap_q <= tap_sel;
         tmr_q <= timer_four_output;
         pin_q <= serial_clock_pin_in;
      end
   end

   wire tap_tick = rise(tap_sel, tap_q);
   wire tmr_tick = rise(timer_four_output, tmr_q);
   wire pin_rise = rise(serial_clock_pin_in, pin_q);
   wire pin_fall = rise(pin_q, serial_clock_pin_in);

   ////////////////////////////////////////////////////////////////////////
   // baud generator divider
   logic [4:0] div_cnt_q;
   logic [3:0] frac_cnt_q;
   logic       stretch_q;
   logic       gen_tick;

   // a zero field stands for the largest ratio
   wire [4:0] n_eff = (divide_ratio_n == 4'h0) ? 5'h10 :
                      {1'b0, divide_ratio_n};
   // fraction only honoured in uart mode with k nonzero; synchronous
   // mode cannot use it, and n of 1 or 16 is left to software
   wire frac_on = fractional_divide_enable & uart_mode &
                  (fraction_k != 4'h0);
   // stretch on periods whose phase is below 16-k
   wire [4:0] stretch_span = 5'h10 - {1'b0, fraction_k};
   wire stretch_now = frac_on &
                      ({1'b0, frac_cnt_q} < stretch_span);
   wire [4:0] period = n_eff + {4'h0, stretch_q};

   // count tap ticks, one output tick per period
   // >= ends a period at once if a new ratio leaves the count above it
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt_q  <= 5'h00;
         frac_cnt_q <= 4'h0;
         stretch_q  <= 1'b0;
      end else if (tap_tick) begin
         if (div_cnt_q + 5'h01 >= period) begin
            div_cnt_q  <= 5'h00;
            frac_cnt_q <= frac_cnt_q + 4'h1;
            stretch_q  <= stretch_now;
         end else begin
            div_cnt_q <= div_cnt_q + 5'h01;
         end
      end
   end
   assign gen_tick = tap_tick && (div_cnt_q + 5'h01 >= period);

   // system clock halved
   // a tick every other cycle, the fastest basic clock there is
   logic half_q;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         half_q <= 1'b0;
      end else begin
         half_q <= ~half_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // basic clock selection
   logic sio_tick;
   logic sclk_q;
   always_comb begin
      if (uart_mode) begin
         unique case (uart_clock_source)
            SRC_BAUD:  sio_tick = gen_tick;
            SRC_HALF:  sio_tick = half_q;
            SRC_TIMER: sio_tick = tmr_tick;
            default:   sio_tick = pin_rise;
         endcase
      end else if (!serial_clock_direction) begin
         sio_tick = gen_tick & sclk_q;
      end else begin
         sio_tick = serial_clock_edge_select ? pin_fall : pin_rise;
      end
   end

   // sync output clock toggles on each generator tick
   // pin idles high; the basic tick takes every second generator tick
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_q <= 1'b1;
      end else if (!uart_mode && !serial_clock_direction && gen_tick) begin
         sclk_q <= ~sclk_q;
      end
   end

   // pin drive and basic clock pulse outputs
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         serial_clock_pin_out  <= 1'b1;
         serial_clock_pin_oe_n <= 1'b1;
         uart_basic_clock      <= 1'b0;
      end else begin
         serial_clock_pin_out  <= sclk_q;
         serial_clock_pin_oe_n <= uart_mode | serial_clock_direction;
         uart_basic_clock      <= sio_tick;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // uart receive counter and majority
   // counter held at zero outside uart mode so it starts clean on entry;
   // start bit alignment happens downstream of this block
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_cnt_q <= 4'h0;
         samp_q   <= 3'h0;
      end else if (!uart_mode) begin
         rx_cnt_q <= 4'h0;
      end else if (sio_tick) begin
         rx_cnt_q <= rx_cnt_q + 4'h1;
         if (rx_cnt_q == SAMPLE_A) samp_q[0] <= rx_line;
         if (rx_cnt_q == SAMPLE_B) samp_q[1] <= rx_line;
         if (rx_cnt_q == SAMPLE_C) samp_q[2] <= rx_line;
      end
   end

   // two of three samples decide the bit
   function automatic logic maj3(input logic [2:0] s);
      return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
   endfunction

   // majority decided on the sixteenth pulse; rx_bit_q feeds the read back
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_bit_q     <= 1'b1;
         rx_bit_valid <= 1'b0;
         rx_bit_value <= 1'b1;
      end else begin
         rx_bit_valid <= uart_mode && sio_tick && rx_cnt_q == LAST_PULSE;
         if (uart_mode && sio_tick && rx_cnt_q == LAST_PULSE) begin
            rx_bit_q     <= maj3(samp_q);
            rx_bit_value <= maj3(samp_q);
         end
      end
   end
endmodule // sbcg_serial_baud_clock_gen
`default_nettype wire

//--- sim/sbcg_props.sv
`timescale 1ns/1ns
`default_nettype none
module sbcg_props (
   input wire logic        ref_clk,
   input wire logic        rst_n,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        serial_clock_pin_out,
   input wire logic        serial_clock_pin_oe_n,
   input wire logic        uart_basic_clock,
   input wire logic        rx_bit_valid
);
   default clocking dc @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   // request seen while the slave still holds off
   sequence req_s;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   a_bus_answer: assert property (req_s |=> !avs_waitrequest)
      else $error("request not answered");
   a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   a_idle_zero: assert property (avs_waitrequest |-> avs_readdata == 32'h0)
      else $error("read data outside answer");
   a_tick_pulse: assert property (
      uart_basic_clock |=> !uart_basic_clock)
      else $error("basic clock not a pulse");
   a_valid_pulse: assert property (rx_bit_valid |=> !rx_bit_valid)
      else $error("bit valid not a pulse");
   a_valid_after_tick: assert property (
      rx_bit_valid |-> uart_basic_clock)
      else $error("bit valid without basic tick");
   a_valid_spacing: assert property (
      rx_bit_valid |=> (!rx_bit_valid) [*8])
      else $error("bit valid too soon");
   a_dir_by_write: assert property (
      $changed(serial_clock_pin_oe_n) |-> $past(avs_write))
      else $error("pin direction moved without write");
   a_pin_quiet: assert property (
      serial_clock_pin_oe_n && $past(serial_clock_pin_oe_n)
      |-> $stable(serial_clock_pin_out))
      else $error("pin clock moves while not driven");
endmodule // sbcg_props
bind sbcg_serial_baud_clock_gen sbcg_props sbcg_props_inst (
   .ref_clk(ref_clk), .rst_n(rst_n), .avs_read(avs_read),
   .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest),
   .serial_clock_pin_out(serial_clock_pin_out),
   .serial_clock_pin_oe_n(serial_clock_pin_oe_n),
   .uart_basic_clock(uart_basic_clock), .rx_bit_valid(rx_bit_valid));
`default_nettype wire

//--- sim/sbcg_remote_peer.sv
`timescale 1ns/1ns
`default_nettype none
module sbcg_remote_peer #(
   parameter int HALF = 10
) (
   input wire logic ref_clk,
   input wire logic run,
   output var logic clk_out
);
   int cnt_q = 0;
   initial clk_out = 1'b1;
   // pin clock runs only in frames, pulled high between them
   always @(posedge ref_clk) begin
      if (!run) begin
         cnt_q <= 0;
         clk_out <= 1'b1;
      end else if (cnt_q == HALF - 1) begin
         cnt_q <= 0;
         clk_out <= !clk_out;
      end else
         cnt_q <= cnt_q + 1;
   end
endmodule // sbcg_remote_peer
`default_nettype wire

//--- sim/serial_baud_clock_gen_bench.sv
`timescale 1ns/1ns
`default_nettype none
module serial_baud_clock_gen_bench
   import sbcg_pkg::*;
;
   localparam logic [7:0] BITS = 8'hA5;
   logic        ref_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [3:0]  adr = 4'h0;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wd = 32'h0;
   logic [31:0] rdata;
   logic        wait_r;
   logic [7:0]  tcnt = 8'h00;
   logic        run = 1'b0;
   logic        peer_clk;
   logic        pin_out;
   logic        oe_n;
   logic        rx_line = 1'b1;
   logic        tick;
   logic        valid;
   logic        value;
   logic        rxon = 1'b0;
   logic [3:0]  pos = 4'h0;
   logic [2:0]  bidx = 3'h0;
   int          vcnt = 0;
   int          cycles = 0;
   int          num_errors = 0;
   int          compares = 0;
   always #4 ref_clk = ~ref_clk;
   // taps and timer from one counter, all below half clock
   always @(posedge ref_clk) tcnt <= tcnt + 8'h01;
   sbcg_serial_baud_clock_gen sbcg_serial_baud_clock_gen_inst (
      .ref_clk(ref_clk), .rst_n(rst_n), .avs_address(adr),
      .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
      .avs_readdata(rdata), .avs_waitrequest(wait_r),
      .prescaler_tap_div1(tcnt[1]), .prescaler_tap_div4(tcnt[3]),
      .prescaler_tap_div16(tcnt[5]), .prescaler_tap_div64(tcnt[7]),
      .timer_four_output(tcnt[4]),
      .serial_clock_pin_in(oe_n ? peer_clk : pin_out),
      .serial_clock_pin_out(pin_out), .serial_clock_pin_oe_n(oe_n),
      .rx_line(rx_line), .uart_basic_clock(tick),
      .rx_bit_valid(valid), .rx_bit_value(value));
   sbcg_remote_peer sbcg_remote_peer_inst (
      .ref_clk(ref_clk), .run(run), .clk_out(peer_clk));
   ////////////////////////////////////////
   task automatic chk(input logic [31:0] e, input logic [31:0] g,
                      input string what);
      compares++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", what, e, g);
         num_errors++;
      end
   endtask
   task automatic av(input logic r, input logic [3:0] a,
                     input logic [31:0] d);
      @(posedge ref_clk);
      adr <= a;
      wd <= d;
      rd <= r;
      wr <= !r;
      do @(posedge ref_clk); while (wait_r !== 1'b0);
      if (r) chk(d, rdata, "read");
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic setup(input logic [6:0] bc, input logic [3:0] k,
                        input logic [2:0] md, input logic [1:0] ct);
      av(1'b0, ADDR_BAUD_CTRL, {25'h0, bc});
      av(1'b0, ADDR_BAUD_FRAC, {28'h0, k});
      av(1'b0, ADDR_SER_CTRL, {30'h0, ct});
      av(1'b0, ADDR_SER_MODE, {29'h0, md});
   endtask
   // cycles over 16 basic periods, first two ticks skipped
   task automatic measure(input int e, input string what);
      int c;
      int k;
      c = 0;
      k = 0;
      while (k < 19) begin
         @(negedge ref_clk);
         c++;
         if (tick === 1'b1) k++;
         if (tick === 1'b1 && k == 3) c = 0;
      end
      chk(e, c, what);
      $display("test %s done", what);
   endtask
   // pin clock changes seen over 256 cycles
   task automatic count_pin(input int e, input string what);
      int n;
      logic p;
      n = 0;
      @(negedge ref_clk);
      p = pin_out;
      repeat (256) begin
         @(negedge ref_clk);
         if (pin_out !== p) n++;
         p = pin_out;
      end
      chk(e, n, what);
   endtask
   task automatic finish_test();
      $display("compares %0d errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   ////////////////////////////////////////
   // receive line: true bit on pulses 7 and 9, inverse elsewhere
   always @(posedge ref_clk) begin
      if (rxon && tick === 1'b1) begin
         pos <= pos + 4'h1;
         if (pos == 4'hF) bidx <= bidx + 3'h1;
         rx_line <= BITS[bidx + {2'h0, pos == 4'hF}] ^ !((pos + 4'h1)
            inside {4'h6, 4'h8});
      end
   end
   always @(negedge ref_clk) begin
      if (rxon && valid === 1'b1) begin
         chk({31'h0, BITS[vcnt[2:0]]}, {31'h0, value}, "rx bit");
         vcnt++;
      end
   end
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 40000) begin
         num_errors++;
         finish_test();
      end
   end
   initial begin
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      av(1'b1, ADDR_BAUD_CTRL, {25'h0, BAUD_CTRL_RST});
      av(1'b1, ADDR_BAUD_FRAC, {28'h0, BAUD_FRAC_RST});
      av(1'b1, ADDR_SER_MODE, {29'h0, SER_MODE_RST});
      av(1'b1, 4'h2, 32'h0);
      $display("test registers done");
      for (int t = 0; t < 4; t++) begin
         setup({1'b0, 2'(t), 4'h2}, 4'hE, 3'h4, 2'h0);
         measure(128 << (2 * t), "tap");
      end
      setup(7'h00, 4'h0, 3'h4, 2'h0);
      measure(1024, "n sixteen");
      setup(7'h44, 4'hE, 3'h4, 2'h0);
      measure(264, "fraction");
      setup(7'h02, 4'h0, 3'h5, 2'h0);
      measure(32, "half clock");
      setup(7'h02, 4'h0, 3'h6, 2'h0);
      measure(512, "timer");
      run <= 1'b1;
      setup(7'h02, 4'h0, 3'h7, 2'h0);
      measure(320, "ext pin");
      setup(7'h02, 4'h0, 3'h0, 2'h0);
      measure(256, "sync out");
      chk(32'h0, {31'h0, oe_n}, "drive");
      count_pin(32, "pin clock");
      av(1'b1, ADDR_SER_CTRL, 32'h0000_0100);
      for (int e = 0; e < 2; e++) begin
         setup(7'h02, 4'h0, 3'h2, {1'b1, 1'(e)});
         measure(320, "sync in");
         chk(32'h1, {31'h0, oe_n}, "release");
         count_pin(0, "pin quiet");
      end
      run <= 1'b0;
      setup(7'h02, 4'h0, 3'h2, 2'h2);
      rxon <= 1'b1;
      av(1'b0, ADDR_SER_MODE, 32'h5);
      while (vcnt < 8) @(posedge ref_clk);
      $display("test receive done");
      finish_test();
   end
endmodule // serial_baud_clock_gen_bench
`default_nettype wire
